// ===== verilog/frequency_locked_loop_ctrl.v
// Register file, reference select and digital loop model for the codec clock generator
`include "loop_ctrl_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module frequency_locked_loop_ctrl (
  input  wire                clk,
  input  wire                rst,
  input  wire                regWrite,
  input  wire                regRead,
  input  wire [`ADDR_W-1:0]  regAddr,
  input  wire [`DATA_W-1:0]  regWriteData,
  output reg  [`DATA_W-1:0]  regReadData,
  input  wire                masterClockPin,
  input  wire                dacFrameClock,
  input  wire                adcFrameClock,
  input  wire                ref32kPin,
  input  wire                ref32kInternal,
  input  wire                ref32kFromPin,
  output reg                 codecSystemClock,
  output reg                 loopRunning
);

  // Control fields
  reg                   loopDigitalOn;
  reg                   loopAnalogOn;
  reg [2:0]             outputDividerSel;
  reg [3:0]             loopGainSel;
  reg [2:0]             controlBlockRate;
  reg [4:0]             vcoRatio;
  reg [9:0]             multInteger;
  reg [15:0]            multFraction;
  reg                   lowRefLock;
  reg                   fractionOn;
  reg [1:0]             refSourceSel;

  // Next values of the control fields
  reg                   next_loopDigitalOn;
  reg                   next_loopAnalogOn;
  reg [2:0]             next_outputDividerSel;
  reg [3:0]             next_loopGainSel;
  reg [2:0]             next_controlBlockRate;
  reg [4:0]             next_vcoRatio;
  reg [9:0]             next_multInteger;
  reg [15:0]            next_multFraction;
  reg                   next_lowRefLock;
  reg                   next_fractionOn;
  reg [1:0]             next_refSourceSel;

  // Register slot codes from the address decoder
  localparam [2:0] SLOT_NONE       = 3'h0;
  localparam [2:0] SLOT_ENABLE_DIV = 3'h1;
  localparam [2:0] SLOT_RATIO_INT  = 3'h2;
  localparam [2:0] SLOT_FRACTION   = 3'h3;
  localparam [2:0] SLOT_REF_MODE   = 3'h4;

  // Address decode shared by the write and read paths
  function [2:0] regSlot;
    input [`ADDR_W-1:0] addr;
    begin
      if (addr == `ADDR_ENABLE_DIV)
        regSlot = SLOT_ENABLE_DIV;
      else if (addr == `ADDR_RATIO_INT)
        regSlot = SLOT_RATIO_INT;
      else if (addr == `ADDR_FRACTION)
        regSlot = SLOT_FRACTION;
      else if (addr == `ADDR_REF_MODE)
        regSlot = SLOT_REF_MODE;
      else
        regSlot = SLOT_NONE;
    end
  endfunction

  wire [2:0] accessSlot = regSlot(regAddr);

  // Register writes; reserved bits are simply not stored
  always @*
  begin
    next_loopDigitalOn    = loopDigitalOn;
    next_loopAnalogOn     = loopAnalogOn;
    next_outputDividerSel = outputDividerSel;
    next_loopGainSel      = loopGainSel;
    next_controlBlockRate = controlBlockRate;
    next_vcoRatio         = vcoRatio;
    next_multInteger      = multInteger;
    next_multFraction     = multFraction;
    next_lowRefLock       = lowRefLock;
    next_fractionOn       = fractionOn;
    next_refSourceSel     = refSourceSel;
    if (regWrite)
    begin
      if (accessSlot == SLOT_ENABLE_DIV)
      begin
        next_loopDigitalOn    = regWriteData[`BIT_DIGITAL_ON];
        next_loopAnalogOn     = regWriteData[`BIT_ANALOG_ON];
        next_outputDividerSel = regWriteData[`OUTDIV_HI:`OUTDIV_LO];
        next_loopGainSel      = regWriteData[`GAIN_HI:`GAIN_LO];
        next_controlBlockRate = regWriteData[`RATE_HI:`RATE_LO];
      end
      else if (accessSlot == SLOT_RATIO_INT)
      begin
        next_vcoRatio    = regWriteData[`RATIO_HI:`RATIO_LO];
        next_multInteger = regWriteData[`MULT_INT_HI:`MULT_INT_LO];
      end
      else if (accessSlot == SLOT_FRACTION)
      begin
        next_multFraction = regWriteData;
      end
      else if (accessSlot == SLOT_REF_MODE)
      begin
        next_lowRefLock   = regWriteData[`BIT_LOW_REF];
        next_fractionOn   = regWriteData[`BIT_FRACTION_ON];
        next_refSourceSel = regWriteData[`SRC_HI:`SRC_LO];
      end
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      loopDigitalOn    <= 1'b0;
      loopAnalogOn     <= 1'b0;
      outputDividerSel <= `RST_OUTDIV;
      loopGainSel      <= `RST_GAIN;
      controlBlockRate <= `RST_RATE;
      vcoRatio         <= `RST_RATIO;
      multInteger      <= `RST_MULT_INT;
      multFraction     <= `RST_MULT_FRAC;
      lowRefLock       <= 1'b0;
      fractionOn       <= 1'b0;
      refSourceSel     <= `RST_SRC;
    end
    else
    begin
      loopDigitalOn    <= next_loopDigitalOn;
      loopAnalogOn     <= next_loopAnalogOn;
      outputDividerSel <= next_outputDividerSel;
      loopGainSel      <= next_loopGainSel;
      controlBlockRate <= next_controlBlockRate;
      vcoRatio         <= next_vcoRatio;
      multInteger      <= next_multInteger;
      multFraction     <= next_multFraction;
      lowRefLock       <= next_lowRefLock;
      fractionOn       <= next_fractionOn;
      refSourceSel     <= next_refSourceSel;
    end
  end

  // Readback image of each register
  function [`DATA_W-1:0] readImage;
    input [2:0] slot;
    begin
      if (slot == SLOT_ENABLE_DIV)
        readImage = {loopDigitalOn, loopAnalogOn, 3'h0, outputDividerSel,
                     loopGainSel, 1'b0, controlBlockRate};
      else if (slot == SLOT_RATIO_INT)
        readImage = {vcoRatio, 1'b0, multInteger};
      else if (slot == SLOT_FRACTION)
        readImage = multFraction;
      else if (slot == SLOT_REF_MODE)
        readImage = {8'h00, lowRefLock, 1'b0, fractionOn, 3'h0, refSourceSel};
      else
        readImage = 16'h0000;
    end
  endfunction

  always @(posedge clk)
  begin
    if (rst)
      regReadData <= 16'h0000;
    else if (regRead)
      regReadData <= readImage(accessSlot);
  end

  // Pin synchronisers, two stages each; the 32k source pick is a pin too
  wire [5:0] pinRaw = {ref32kFromPin, ref32kInternal, ref32kPin, adcFrameClock,
                       dacFrameClock, masterClockPin};
  reg  [5:0] pinMeta;
  reg  [5:0] pinSync;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : gSync
      always @(posedge clk)
      begin
        if (rst)
        begin
          pinMeta[gi] <= 1'b0;
          pinSync[gi] <= 1'b0;
        end
        else
        begin
          pinMeta[gi] <= pinRaw[gi];
          pinSync[gi] <= pinMeta[gi];
        end
      end
    end
  endgenerate

  // Reference mux; ADC frame is only meaningful in slave mode
  reg refSelected;
  always @*
  begin
    case (refSourceSel)
      `SRC_MCLK:      refSelected = pinSync[0];
      `SRC_DAC_FRAME: refSelected = pinSync[1];
      `SRC_ADC_FRAME: refSelected = pinSync[2];
      default:        refSelected = pinSync[5] ? pinSync[3] : pinSync[4];
    endcase
  end

  reg refPrev;
  wire refEdge = refSelected & ~refPrev;

  // Oscillator model: phase accumulator tuned by the loop
  reg  [`ACC_W-1:0]  phaseAcc;
  reg  [`TUNE_W-1:0] tuneWord;
  wire [`ACC_W:0]    phaseSum = {1'b0, phaseAcc} + {1'b0, tuneWord};
  wire               oscTick = loopAnalogOn & phaseSum[`ACC_W];

  always @(posedge clk)
  begin
    if (rst || !loopAnalogOn)
      phaseAcc <= {`ACC_W{1'b0}};
    else
      phaseAcc <= phaseSum[`ACC_W-1:0];
  end

  // Control block clock: one tick per 2^rate oscillator ticks, capped at 32 for rate 5 to 7
  reg  [4:0] rateCnt;
  wire [4:0] rateMask = (5'h01 << controlBlockRate) - 5'h01;
  wire       ctrlTick = oscTick & ((rateCnt & rateMask) == 5'h00);

  // Target count per reference period, 16 fractional bits
  wire [25:0] multFull = {multInteger, fractionOn ? multFraction : 16'h0000};
  wire [30:0] targetRaw = multFull * vcoRatio;
  wire [30:0] targetScaled = targetRaw >> controlBlockRate;

  reg  [`CNT_W-1:0] ctrlCount;
  wire signed [`ERR_W-1:0] freqErr =
    $signed({9'h000, targetScaled}) - $signed({ctrlCount, 16'h0000});
  wire [5:0] attenShift = lowRefLock ? (`LOOP_ATTEN + `LOW_REF_ATTEN) : `LOOP_ATTEN;
  // Low references give sparse corrections, so the step is damped harder
  wire signed [`ERR_W-1:0] errScaled = (freqErr <<< loopGainSel) >>> attenShift;
  wire [`TUNE_W-1:0] next_tuneWord = tuneWord + errScaled[`TUNE_W-1:0];

  always @(posedge clk)
  begin
    if (rst || !loopDigitalOn)
    begin
      refPrev     <= 1'b0;
      rateCnt     <= 5'h00;
      ctrlCount   <= {`CNT_W{1'b0}};
      tuneWord    <= `TUNE_RST;
      loopRunning <= 1'b0;
    end
    else
    begin
      refPrev <= refSelected;
      if (oscTick)
        rateCnt <= rateCnt + 5'h01;
      loopRunning <= loopAnalogOn;
      if (refEdge)
      begin
        ctrlCount <= {`CNT_W{1'b0}};
        if (loopAnalogOn)
          tuneWord <= next_tuneWord;
      end
      else if (ctrlTick && ctrlCount != {`CNT_W{1'b1}})
        ctrlCount <= ctrlCount + {{`CNT_W-1{1'b0}}, 1'b1};
    end
  end

  // Output divider: toggle every 2^code oscillator ticks, giving /2 .. /32
  reg  [4:0] divCnt;
  wire [2:0] divCode = (outputDividerSel > `OUTDIV_MAX) ? `OUTDIV_MAX : outputDividerSel;
  wire [4:0] divMask = (5'h01 << divCode) - 5'h01;

  always @(posedge clk)
  begin
    if (rst || !loopDigitalOn || !loopAnalogOn)
    begin
      divCnt           <= 5'h00;
      codecSystemClock <= 1'b0;
    end
    else if (oscTick)
    begin
      divCnt <= divCnt + 5'h01;
      if ((divCnt & divMask) == divMask)
        codecSystemClock <= ~codecSystemClock;
    end
  end

endmodule // frequency_locked_loop_ctrl

`default_nettype wire

// ===== verilog/loop_ctrl_defines.vh
// Register map, field positions and reset values for the frequency-locked loop control
`ifndef LOOP_CTRL_DEFINES_VH
`define LOOP_CTRL_DEFINES_VH

`define ADDR_W              8
`define DATA_W              16
`define ADDR_ENABLE_DIV     8'h2A
`define ADDR_RATIO_INT      8'h2B
`define ADDR_FRACTION       8'h2C
`define ADDR_REF_MODE       8'h2D

`define BIT_DIGITAL_ON      15
`define BIT_ANALOG_ON       14
`define OUTDIV_HI           10
`define OUTDIV_LO           8
`define GAIN_HI             7
`define GAIN_LO             4
`define RATE_HI             2
`define RATE_LO             0
`define RATIO_HI            15
`define RATIO_LO            11
`define MULT_INT_HI         9
`define MULT_INT_LO         0
`define BIT_LOW_REF         7
`define BIT_FRACTION_ON     5
`define SRC_HI              1
`define SRC_LO              0

`define RST_OUTDIV          3'h2
`define RST_GAIN            4'h0
`define RST_RATE            3'h0
`define RST_RATIO           5'h0E
`define RST_MULT_INT        10'h086
`define RST_MULT_FRAC       16'hC226
`define RST_SRC             2'h0

`define SRC_MCLK            2'h0
`define SRC_DAC_FRAME       2'h1
`define SRC_ADC_FRAME       2'h2
`define SRC_32K             2'h3

`define OUTDIV_MAX          3'h4
`define ENABLE_DIV_MASK     16'hC7F7
`define RATIO_INT_MASK      16'hFBFF
`define REF_MODE_MASK       16'h00A3

`define ACC_W               32
`define TUNE_W              32
`define TUNE_RST            32'h2000_0000
`define ERR_W               40
`define LOOP_ATTEN          6'h10
`define LOW_REF_ATTEN       6'h04
`define CNT_W               24

`endif

// ===== tb/ref_clock_source.sv
// Reference clock sources for the loop control block
`timescale 1ns/1ps
`default_nettype none
module ref_clock_source (
  input  wire logic refOn,
  output var  logic masterClock,
  output var  logic dacFrame,
  output var  logic adcFrame,
  output var  logic pin32k,
  output var  logic osc32k
);
  initial {masterClock, dacFrame, adcFrame, pin32k, osc32k} = 5'h00;
  // Held still when off, so the loop sees no stray edges
  always #100 if (refOn) masterClock = ~masterClock;
  always #1300 if (refOn) dacFrame = ~dacFrame;
  always #1700 if (refOn) adcFrame = ~adcFrame;
  always #2900 if (refOn) pin32k = ~pin32k;
  always #3100 if (refOn) osc32k = ~osc32k;
endmodule // ref_clock_source
`default_nettype wire

// ===== tb/loop_ctrl_monitor.sv
// Port checks for the loop control block
`timescale 1ns/1ps
`default_nettype none
module loop_ctrl_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWriteData,
  input wire logic [15:0] regReadData,
  input wire logic        codecSystemClock,
  input wire logic        loopRunning
);
  logic [15:0] ctl;
  logic [1:0]  ens;
  assign ens = ctl[15:14];
  always @(posedge clk)
  begin
    if (rst)
      ctl <= 16'h0200;
    else if (regWrite && regAddr == 8'h2A)
      ctl <= regWriteData & 16'hC7F7;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_both_on;
    regWrite && regAddr == 8'h2A && regWriteData[15:14] == 2'h3;
  endsequence
  a_run_after_on: assert property (s_both_on |=> ##1 loopRunning)
    else $error("loop idle after both enables");
  a_run_needs_on: assert property (loopRunning |-> $past(ens) == 2'h3)
    else $error("loop running without both enables");
  a_clock_held_off: assert property ((ens != 2'h3) [*2] |-> !codecSystemClock)
    else $error("system clock active while disabled");
  a_ctl_readback: assert property (regRead && regAddr == 8'h2A |=> regReadData == $past(ctl))
    else $error("first control register readback wrong");
  a_ratio_mask: assert property (regRead && regAddr == 8'h2B |=> !regReadData[10])
    else $error("unused ratio bit reads set");
  a_mode_mask: assert property (regRead && regAddr == 8'h2D |=> (regReadData & 16'hFF5C) == 16'h0000)
    else $error("unused mode bits read set");
  a_unmapped_zero: assert property (regRead && (regAddr < 8'h2A || regAddr > 8'h2D) |=> regReadData == 16'h0000)
    else $error("unmapped read not zero");
  a_read_holds: assert property (!regRead |=> $stable(regReadData))
    else $error("read data moved without a read");
endmodule // loop_ctrl_monitor
bind frequency_locked_loop_ctrl loop_ctrl_monitor mon_u (.clk(clk), .rst(rst),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
  .regReadData(regReadData), .codecSystemClock(codecSystemClock), .loopRunning(loopRunning));
`default_nettype wire

// ===== tb/frequency_locked_loop_ctrl_test.sv
// Self-checking bench for the loop control block
`timescale 1ns/1ps
`default_nettype none
module frequency_locked_loop_ctrl_test;
  logic clk, rst, regWrite, regRead, refOn, ref32kFromPin;
  logic [7:0] regAddr;
  logic [15:0] regWriteData;
  logic [15:0] model [8];
  logic [15:0] mask [8] = '{16'h0000, 16'h0000, 16'hC7F7, 16'hFBFF, 16'hFFFF, 16'h00A3,
    16'h0000, 16'h0000};
  int bad_count, check_count, n, m;
  wire [15:0] regReadData;
  wire mClk, dClk, aClk, pClk, oClk, codec_system_clock, running;
  ref_clock_source src_u (.refOn(refOn), .masterClock(mClk), .dacFrame(dClk),
    .adcFrame(aClk), .pin32k(pClk), .osc32k(oClk));
  frequency_locked_loop_ctrl dut_u (.clk(clk), .rst(rst), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
    .regReadData(regReadData), .masterClockPin(mClk), .dacFrameClock(dClk),
    .adcFrameClock(aClk), .ref32kPin(pClk), .ref32kInternal(oClk),
    .ref32kFromPin(ref32kFromPin), .codecSystemClock(codec_system_clock), .loopRunning(running));
  always #12.5 clk = ~clk;
  task stop_test;
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask
  // Addresses 28h..2Fh only; low three bits index the model
  function automatic logic [15:0] fit(input logic [7:0] a, input logic [15:0] d);
    fit = d & mask[a[2:0]];
  endfunction
  // Every access also reads, so a write returns the old value
  task op(input logic w, input logic [7:0] a, input logic [15:0] d);
    logic [15:0] e;
    e = model[a[2:0]];
    regWrite <= w;
    regRead <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    if (w)
      model[a[2:0]] = fit(a, d);
    @(posedge clk);
    chk("readData", 32'(e), 32'(regReadData));
  endtask
  task edgeWait(input logic v, output int k);
    k = 0;
    while (codec_system_clock !== v && k < 999)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 999)
    begin
      bad_count++;
      stop_test;
    end
  endtask
  initial
  begin
    {clk, rst, regWrite, regRead, refOn, ref32kFromPin} = 6'h10;
    regAddr = 8'h00;
    regWriteData = 16'h0000;
    bad_count = 0;
    check_count = 0;
    void'($urandom(32'hBED36ADB));
    // Second pass resets in mid-run
    for (int p = 0; p < 2; p++)
    begin
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      model = '{16'h0000, 16'h0000, 16'h0200, 16'h7086, 16'hC226, 16'h0000, 16'h0000,
        16'h0000};
      for (int i = 0; i < 8; i++)
        op(1'b0, 8'(40 + i), 16'h0000);
      // Quiet references keep the tuning word at reset, so periods are exact
      refOn <= 1'b0;
      for (int c = 0; c < 5; c++)
      begin
        op(1'b1, 8'h2A, 16'h4000 | 16'(c << 8));
        op(1'b1, 8'h2A, 16'hC000 | 16'(c << 8));
        @(posedge clk);
        chk("running", 32'h1, 32'(running));
        edgeWait(1'b0, n);
        edgeWait(1'b1, n);
        edgeWait(1'b0, n);
        edgeWait(1'b1, m);
        chk("period", 32'(1 << (c + 4)), 32'(n + m));
      end
      op(1'b1, 8'h2A, 16'h4200);
      repeat (2) @(posedge clk);
      chk("running", 32'h0, 32'(running));
      chk("codec_system_clock", 32'h0, 32'(codec_system_clock));
      refOn <= 1'b1;
      for (int s = 0; s < 4; s++)
      begin
        ref32kFromPin <= 1'($urandom);
        op(1'b1, 8'h2D, 16'h00A0 | 16'(s));
        op(1'b1, 8'h2A, 16'hC000);
        edgeWait(1'b1, n);
        edgeWait(1'b0, n);
        op(1'b1, 8'h2A, 16'h4000);
      end
      for (int i = 0; i < 30; i++)
        op(1'b1, 8'(40 + $urandom_range(7)), 16'($urandom));
    end
    stop_test;
  end
endmodule // frequency_locked_loop_ctrl_test
`default_nettype wire
